// [core/plc_math_pkg.sv]
/*
 * Shared types and constants of the controller math unit: operation and
 * data-type codes, the request carrier, integer limits and the fields of
 * the single-precision floating-point format.
 * Assumes every design file imports the whole package.
 */
package plc_math_pkg;

   typedef enum logic [2:0] {
      OP_ADD = 3'h0,
      OP_SUB = 3'h1,
      OP_MUL = 3'h2,
      OP_DIV = 3'h3,
      OP_MOD = 3'h4
   } op_t;

   typedef enum logic [1:0] {
      DT_INT16         = 2'h0,
      DT_SIGNED_32_TYPE = 2'h1,
      DT_REAL          = 2'h2
   } dtype_t;

   // a 32-bit value is two 16-bit words, low word first in memory
   typedef struct packed {
      logic [15:0] upper;
      logic [15:0] lower;
   } word_pair_t;

   typedef struct packed {
      op_t        op;
      dtype_t     dtype;
      word_pair_t first_operand;
      word_pair_t second_operand;
   } req_t;

   typedef struct packed {
      logic [31:0] value;
      logic        ok;
   } real_res_t;

   localparam int WIDE_W = 66;
   localparam logic signed [WIDE_W-1:0] INT16_MAX_W = 66'sh7FFF;
   localparam logic signed [WIDE_W-1:0] INT16_MIN_W = -66'sh8000;
   localparam logic signed [WIDE_W-1:0] INT32_MAX_W = 66'sh7FFF_FFFF;
   localparam logic signed [WIDE_W-1:0] INT32_MIN_W = -66'sh8000_0000;

   localparam logic [31:0] RESULT_RST    = 32'h0000_0000;
   localparam int          REAL_EXP_LSB  = 23;
   localparam int          MANT_POINT    = 46;
   localparam logic [7:0]  REAL_EXP_NAN  = 8'hFF;
   localparam logic signed [11:0] REAL_BIAS    = 12'sh07F;
   localparam logic signed [11:0] REAL_EXP_TOP = 12'sh0FF;
   localparam logic [30:0] REAL_MAX_MAG  = 31'h7F7F_FFFF;

endpackage

// [core/real_math_core.sv]
/*
 * Combinational single-precision add, subtract, multiply and divide.
 * Assumes the caller registers the result; subnormals flush to zero,
 * results truncate, infinities and NaN on input count as invalid.
 */
`timescale 1ns/100ps
module real_math_core
   import plc_math_pkg::*;
(
   // request
   input  wire op_t         i_op,
   input  wire logic [31:0] i_a,
   input  wire logic [31:0] i_b,
   // answer
   output real_res_t        o_res
);

   // m holds the magnitude with its binary point at MANT_POINT
   function automatic real_res_t pack_real(input logic s,
                                           input logic signed [11:0] e,
                                           input logic [49:0] m);
      real_res_t         r;
      int                p;
      logic [49:0]       n;
      logic signed [11:0] be;
      r.value = {s, 31'h0000_0000};
      r.ok    = 1'b1;
      p       = 0;
      n       = m;
      be      = 12'sh000;
      for (int i = 0; i < 50; i++) begin
         if (m[i]) p = i;
      end
      if (m != 50'h0) begin
         if (p > MANT_POINT) n = m >> (p - MANT_POINT);
         else n = m << (MANT_POINT - p);
         be = e + 12'(p - MANT_POINT) + REAL_BIAS;
         // overflow saturates with the proper sign
         if (be >= REAL_EXP_TOP) begin
            r.value = {s, REAL_MAX_MAG};
            r.ok    = 1'b0;
         end else if (be > 12'sh000) begin
            r.value = {s, be[7:0], n[MANT_POINT-1 -: REAL_EXP_LSB]};
         end
      end
      return r;
   endfunction

   logic              sa, sb, sb_eff, a_big;
   logic [7:0]        ea, eb, diff;
   logic [23:0]       ma, mb;
   logic signed [11:0] xa, xb;
   logic [49:0]       wa, wb, wbig, wsml;
   logic [47:0]       prod;
   logic [69:0]       quot;

   always_comb begin
      sa     = i_a[31];
      sb     = i_b[31];
      ea     = i_a[30:23];
      eb     = i_b[30:23];
      ma     = (ea == 8'h00) ? 24'h00_0000 : {1'b1, i_a[22:0]};
      mb     = (eb == 8'h00) ? 24'h00_0000 : {1'b1, i_b[22:0]};
      xa     = $signed({4'h0, ea}) - REAL_BIAS;
      xb     = $signed({4'h0, eb}) - REAL_BIAS;
      sb_eff = sb ^ (i_op == OP_SUB);
      a_big  = (ea > eb) || ((ea == eb) && (ma >= mb));
      diff   = a_big ? (ea - eb) : (eb - ea);
      wa     = {3'h0, ma, 23'h00_0000};
      wb     = {3'h0, mb, 23'h00_0000};
      wbig   = a_big ? wa : wb;
      wsml   = (a_big ? wb : wa) >> diff;
      prod   = ma * mb;
      quot   = {ma, 46'h0} / ((mb == 24'h00_0000) ? 70'h1 : 70'(mb));
      o_res  = '{value: RESULT_RST, ok: 1'b0};
      // operations on floating point
      if (ea == REAL_EXP_NAN || eb == REAL_EXP_NAN) begin
         o_res = '{value: RESULT_RST, ok: 1'b0};
      end else if (i_op == OP_ADD || i_op == OP_SUB) begin
         if (sa == sb_eff)
            o_res = pack_real(a_big ? sa : sb_eff, a_big ? xa : xb,
                              wbig + wsml);
         else
            o_res = pack_real(a_big ? sa : sb_eff, a_big ? xa : xb,
                              wbig - wsml);
      end else if (i_op == OP_MUL) begin
         o_res = pack_real(sa ^ sb, xa + xb, {2'h0, prod});
      end else if (i_op == OP_DIV) begin
         // zero divisor is invalid: extreme value, flag dropped
         if (mb == 24'h00_0000)
            o_res = '{value: {sa ^ sb, REAL_MAX_MAG}, ok: 1'b0};
         else
            o_res = pack_real(sa ^ sb, xa - xb, quot[49:0]);
      end
   end

endmodule

// [core/plc_integer_math_unit.sv]
/*
 * Controller math unit: add, subtract, multiply and divide on 16-bit
 * signed, 32-bit signed or floating-point operands, modulo on the integer ones, with a result
 * and a success flag registered one clock after an enabled request.
 * Assumes the requesting logic runs on i_clk_sys and keeps its operands
 * in one shared type, widened or narrowed by itself beforehand.
 */
//
// Contract
// - enable applies operation, first op left-hand
// - four operations on three data types
// - integer division truncates, no rounding correction
// - overflow saturates with sign, flag low
// - flag high only without overflow or invalid
// - 32-bit value: low word first, sign-extended
// - modulo only on the integer types
// - remainder is dividend minus quotient times divisor
// - remainder sign follows the dividend
// - modulo flag high unless divisor zero
`timescale 1ns/100ps
module plc_integer_math_unit
   import plc_math_pkg::*;
(
   // clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst,
   // request from program execution
   input  wire logic        i_enable,
   input  wire req_t        i_req,
   // answer
   output logic [31:0]      o_result,
   output logic             o_ok
);

   logic signed [31:0]       a32;
   logic signed [31:0]       b32;
   logic signed [WIDE_W-1:0] wa;
   logic signed [WIDE_W-1:0] wb;
   logic signed [WIDE_W-1:0] wb_safe;
   logic signed [WIDE_W-1:0] quo;
   logic signed [WIDE_W-1:0] wr;
   logic signed [WIDE_W-1:0] lim_max;
   logic signed [WIDE_W-1:0] lim_min;
   logic                     div_zero;
   logic [31:0]              int_res;
   logic                     int_ok;
   logic [31:0]              res_d;
   logic                     ok_d;
   real_res_t                real_res;

   // 16-bit operands live in the low word and are sign-extended
   always_comb begin
      if (i_req.dtype == DT_INT16) begin
         a32 = {{16{i_req.first_operand.lower[15]}},
                i_req.first_operand.lower};
         b32 = {{16{i_req.second_operand.lower[15]}},
                i_req.second_operand.lower};
      end else begin
         a32 = i_req.first_operand;
         b32 = i_req.second_operand;
      end
   end

   // wide arithmetic so that no integer result can wrap before the clamp
   always_comb begin
      wa       = WIDE_W'(a32);
      wb       = WIDE_W'(b32);
      div_zero = (b32 == 32'sh0000_0000);
      wb_safe  = div_zero ? 66'sh1 : wb;
      // quotient truncates, nothing rounds it afterwards
      quo      = wa / wb_safe;
      lim_max  = (i_req.dtype == DT_INT16) ? INT16_MAX_W : INT32_MAX_W;
      lim_min  = (i_req.dtype == DT_INT16) ? INT16_MIN_W : INT32_MIN_W;
      // first operand always on the left of the operator
      case (i_req.op)
         OP_ADD:  wr = wa + wb;
         OP_SUB:  wr = wa - wb;
         OP_MUL:  wr = wa * wb;
         OP_DIV:  wr = quo;
         // dividend minus quotient times divisor; sign follows the
         // dividend because the quotient truncates
         OP_MOD:  wr = wa - quo * wb;
         default: wr = '0;
      endcase
   end

   always_comb begin
      int_res = wr[31:0];
      int_ok  = 1'b1;
      if (!(i_req.op inside {OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_MOD})) begin
         // unused op code counts as an invalid operation
         int_res = RESULT_RST;
         int_ok  = 1'b0;
      end else if (div_zero && i_req.op == OP_MOD) begin
         int_res = RESULT_RST;
         int_ok  = 1'b0;
      end else if (div_zero && i_req.op == OP_DIV) begin
         // invalid divide: signed extreme of the dividend's sign
         int_res = (wa < 0) ? lim_min[31:0] : lim_max[31:0];
         int_ok  = 1'b0;
      end else if (wr > lim_max) begin
         int_res = lim_max[31:0];
         int_ok  = 1'b0;
      end else if (wr < lim_min) begin
         int_res = lim_min[31:0];
         int_ok  = 1'b0;
      end
   end

   real_math_core u_real (
      .i_op  (i_req.op),
      .i_a   (i_req.first_operand),
      .i_b   (i_req.second_operand),
      .o_res (real_res)
   );

   // type selects the datapath
   always_comb begin
      if (i_req.dtype == DT_REAL) begin
         if (i_req.op == OP_MOD) begin
            res_d = RESULT_RST;
            ok_d  = 1'b0;
         end else begin
            res_d = real_res.value;
            ok_d  = real_res.ok;
         end
      end else if (i_req.dtype == DT_INT16 ||
                   i_req.dtype == DT_SIGNED_32_TYPE) begin
         res_d = int_res;
         ok_d  = int_ok;
      end else begin
         // unused type code: treated as an invalid operation
         res_d = RESULT_RST;
         ok_d  = 1'b0;
      end
   end

   // result moves only on reset or on an enabled request
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) o_result <= RESULT_RST;
      else if (i_enable) o_result <= res_d;
   end

   // flag is a one-request answer, low whenever idle
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) o_ok <= 1'b0;
      else o_ok <= i_enable & ok_d;
   end

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   sequence s_mod_int;
      i_enable && i_req.op == OP_MOD
         && (i_req.dtype == DT_INT16 || i_req.dtype == DT_SIGNED_32_TYPE);
   endsequence

   sequence s_add32;
      i_enable && i_req.op == OP_ADD && i_req.dtype == DT_SIGNED_32_TYPE;
   endsequence

   sequence s_div32;
      i_enable && i_req.op == OP_DIV && i_req.dtype == DT_SIGNED_32_TYPE
         && b32 != 0 && !(a32 == 32'sh8000_0000 && b32 == -32'sh1);
   endsequence

   chk_idle_flag_low: assert property (
      !i_enable |=> !o_ok)
      else $error("flag high after idle cycle");

   chk_idle_result_held: assert property (
      !i_enable |=> $stable(o_result))
      else $error("result moved while idle");

   chk_mod_zero_div: assert property (
      s_mod_int and (b32 == 0) |=> !o_ok)
      else $error("modulo by zero kept flag high");

   chk_mod_flag_set: assert property (
      s_mod_int and (b32 != 0) |=> o_ok)
      else $error("modulo flag low with nonzero divisor");

   chk_mod_rem_value: assert property (
      s_mod_int and (b32 != 0) and (i_req.dtype == DT_SIGNED_32_TYPE)
      |=> o_result == 32'($past(wa) - ($past(wa) / $past(wb)) * $past(wb)))
      else $error("remainder formula mismatch");

   chk_mod_rem_sign: assert property (
      s_mod_int and (b32 != 0) and (a32 >= 0) |=> !o_result[31])
      else $error("remainder sign differs from dividend");

   chk_div_truncate: assert property (
      s_div32 |=> o_result == 32'($past(a32) / $past(b32)) && o_ok)
      else $error("integer quotient not truncated");

   chk_add16_saturate: assert property (
      i_enable && i_req.op == OP_ADD && i_req.dtype == DT_INT16
      && (wa + wb) > INT16_MAX_W |=> o_result == 32'h0000_7FFF && !o_ok)
      else $error("16-bit add overflow not saturated");

   chk_add32_clean: assert property (
      s_add32 and ((wa + wb) <= INT32_MAX_W) and ((wa + wb) >= INT32_MIN_W)
      |=> o_ok && o_result == 32'($past(wa) + $past(wb)))
      else $error("clean 32-bit add lost flag or value");

   chk_sub_order: assert property (
      i_enable && i_req.op == OP_SUB && i_req.dtype == DT_INT16
      && (wa - wb) <= INT16_MAX_W && (wa - wb) >= INT16_MIN_W
      |=> o_result == 32'($past(wa) - $past(wb)))
      else $error("subtraction operands swapped");

   chk_real_mod_refused: assert property (
      i_enable && i_req.op == OP_MOD && i_req.dtype == DT_REAL |=> !o_ok)
      else $error("modulo on floating point accepted");

   chk_bad_op_refused: assert property (
      i_enable && i_req.op > OP_MOD |=> !o_ok)
      else $error("unused op code kept flag high");

   chk_int16_sign_ext: assert property (
      i_enable && i_req.dtype == DT_INT16
      |=> o_result[31:16] == {16{o_result[15]}})
      else $error("16-bit result not sign-extended");

endmodule

// [verification/exec_requester.sv]
/*
 * Model of the program-execution side that requests work from the math
 * unit: it widens 16-bit operands and drives enable and request.
 * Assumes the unit samples its request on the rising edge of i_clk_sys.
 */
`timescale 1ns/100ps
module exec_requester
   import plc_math_pkg::*;
(
   // clock
   input  wire logic i_clk_sys,
   // request to the unit
   output logic      o_enable,
   output req_t      o_req
);
   initial begin
      o_enable = 1'b0;
      o_req    = '0;
   end

   // sign copied into the upper word, low word kept as is
   function automatic word_pair_t widen(logic [15:0] v);
      return {{16{v[15]}}, v};
   endfunction

   // a value narrows only if its upper word is all zeros or all ones
   function automatic logic fits_int16(word_pair_t w);
      return w.upper == 16'h0000 || w.upper == 16'hFFFF;
   endfunction

   // both operands share one type
   task automatic issue(op_t op, dtype_t dt, logic [31:0] a,
                        logic [31:0] b);
      @(negedge i_clk_sys);
      o_enable <= 1'b1;
      o_req.op <= op;
      o_req.dtype <= dt;
      o_req.first_operand <= dt == DT_INT16 ? widen(a[15:0]) : a;
      o_req.second_operand <= dt == DT_INT16 ? widen(b[15:0]) : b;
   endtask

   // idle request lines stop showing the last operands
   task automatic rest();
      @(negedge i_clk_sys);
      o_enable <= 1'b0;
      o_req <= req_t'(~o_req);
   endtask
endmodule

// [verification/testbench.sv]
/*
 * Self-checking bench of the math unit: corner cases, then random
 * integer work, with expectations computed here.
 * Assumes the requester model drives the unit's request side.
 */
`timescale 1ns/100ps
module testbench
   import plc_math_pkg::*;
;
   logic        i_clk_sys = 1'b0;
   logic        i_rst     = 1'b1;
   logic        i_enable;
   req_t        i_req;
   logic [31:0] o_result;
   logic        o_ok;
   logic [31:0] last_res  = 32'h0;
   logic [31:0] seed      = 32'h0833;
   int          fails     = 0;
   int          tests_run = 0;

   always #4 i_clk_sys = ~i_clk_sys;

   exec_requester req (
      .i_clk_sys (i_clk_sys),
      .o_enable  (i_enable),
      .o_req     (i_req)
   );

   plc_integer_math_unit dut (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_enable  (i_enable),
      .i_req     (i_req),
      .o_result  (o_result),
      .o_ok      (o_ok)
   );

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [32:0] model(op_t op, dtype_t dt,
                                         logic [31:0] a, logic [31:0] b);
      longint x, y, r, hi;
      logic   ok;
      x  = dt == DT_INT16 ? longint'($signed(a[15:0])) : longint'($signed(a));
      y  = dt == DT_INT16 ? longint'($signed(b[15:0])) : longint'($signed(b));
      hi = dt == DT_INT16 ? 64'sh7FFF : 64'sh7FFF_FFFF;
      ok = 1'b1;
      case (op)
         OP_ADD: r = x + y;
         OP_SUB: r = x - y;
         OP_MUL: r = x * y;
         OP_DIV: begin
            ok = y != 0;
            r  = ok ? x / y : (x < 0 ? -hi - 1 : hi);
         end
         default: begin
            ok = y != 0;
            r  = ok ? x % y : 0;
         end
      endcase
      if (r > hi || r < -hi - 1) begin
         ok = 1'b0;
         r  = r > hi ? hi : -hi - 1;
      end
      return {ok, r[31:0]};
   endfunction

   task automatic check_word(string what, logic [31:0] e, logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic check_bit(string what, logic e, logic g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %b seen %b", what, e, g);
      end
   endtask

   task automatic check_op(op_t op, dtype_t dt, logic [31:0] a,
                           logic [31:0] b, logic [32:0] e);
      req.issue(op, dt, a, b);
      @(posedge i_clk_sys);
      #1;
      check_word("result", e[31:0], o_result);
      check_bit("ok", e[32], o_ok);
      if (dt == DT_INT16)
         check_bit("narrow fits", 1'b1, req.fits_int16(o_result));
      last_res = e[31:0];
   endtask

   task automatic run_int(op_t op, dtype_t dt, logic [31:0] a,
                          logic [31:0] b);
      check_op(op, dt, a, b, model(op, dt, a, b));
   endtask

   task automatic idle_chk();
      req.rest();
      @(posedge i_clk_sys);
      #1;
      check_word("held result", last_res, o_result);
      check_bit("idle ok", 1'b0, o_ok);
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // a few hundred requests need well under this span
   initial begin
      #(8 * 20000);
      fails++;
      give_verdict();
   end

   initial begin
      logic [31:0] a;
      logic [31:0] b;
      repeat (3) @(posedge i_clk_sys);
      @(negedge i_clk_sys);
      i_rst <= 1'b0;
      check_word("reset result", 32'h0, o_result);
      check_bit("reset ok", 1'b0, o_ok);
      run_int(OP_ADD, DT_INT16, 32'h5, 32'h7);
      idle_chk();
      run_int(OP_DIV, DT_INT16, 32'h18, 32'h5);
      run_int(OP_DIV, DT_SIGNED_32_TYPE, 32'hFFFF_FFE8, 32'h5);
      run_int(OP_MOD, DT_INT16, 32'hFFF9, 32'h3);
      run_int(OP_MOD, DT_SIGNED_32_TYPE, 32'h7, 32'hFFFF_FFFD);
      run_int(OP_MOD, DT_INT16, 32'h9, 32'h0);
      run_int(OP_ADD, DT_INT16, 32'h7FFF, 32'h1);
      run_int(OP_SUB, DT_SIGNED_32_TYPE, 32'h8000_0000, 32'h1);
      run_int(OP_MUL, DT_SIGNED_32_TYPE, 32'h2710, 32'h0004_93E0);
      run_int(OP_DIV, DT_SIGNED_32_TYPE, 32'h8000_0000, 32'hFFFF_FFFF);
      run_int(OP_DIV, DT_INT16, 32'hFFF0, 32'h0);
      idle_chk();
      check_op(OP_MOD, DT_REAL, 32'h4040_0000, 32'h3F80_0000, 33'h0);
      check_op(OP_ADD, DT_REAL, 32'h7FC0_0000, 32'h3F80_0000, 33'h0);
      check_op(op_t'(3'h5), DT_INT16, 32'h3, 32'h4, 33'h0);
      check_op(OP_ADD, dtype_t'(2'h3), 32'h3, 32'h4, 33'h0);
      check_op(OP_ADD, DT_REAL, 32'h3FC0_0000, 32'h4010_0000,
               {1'b1, 32'h4070_0000});
      check_op(OP_SUB, DT_REAL, 32'h40A0_0000, 32'h3FC0_0000,
               {1'b1, 32'h4060_0000});
      check_op(OP_MUL, DT_REAL, 32'h4000_0000, 32'h4040_0000,
               {1'b1, 32'h40C0_0000});
      check_op(OP_DIV, DT_REAL, 32'h40C0_0000, 32'h4000_0000,
               {1'b1, 32'h4040_0000});
      check_op(OP_MUL, DT_REAL, 32'h7F7F_FFFF, 32'h4000_0000,
               {1'b0, 32'h7F7F_FFFF});
      check_op(OP_DIV, DT_REAL, 32'hBF80_0000, 32'h0,
               {1'b0, 32'hFF7F_FFFF});
      // reset in mid-run clears the answer; first idle edge keeps it
      req.rest();
      i_rst    <= 1'b1;
      last_res  = 32'h0;
      @(negedge i_clk_sys);
      i_rst <= 1'b0;
      check_word("rerun result", 32'h0, o_result);
      check_bit("rerun ok", 1'b0, o_ok);
      @(posedge i_clk_sys);
      #1;
      check_word("rerun held", 32'h0, o_result);
      check_bit("rerun idle ok", 1'b0, o_ok);
      for (int k = 0; k < 300; k++) begin
         a = rnd() >> (rnd() & 32'h1F);
         b = rnd() >> (rnd() & 32'h1F);
         run_int(op_t'(3'(rnd() % 5)), dtype_t'(2'(rnd() & 32'h1)), a,
                 b);
         if (k % 7 == 0)
            idle_chk();
      end
      give_verdict();
   end
endmodule
